// ===== hdl/xop_ctl_if.sv
// Decoded X select controls passed from the decoder to the path
`timescale 1ns/1ps
`default_nettype none

interface xop_ctl_if;
	logic             hi_byte_gate;
	logic             mid_gate;
	logic             lo_byte_gate;
	logic             byte_swap;
	xop_pkg::xop_src_t operand_sel;

	modport decoder (
		output hi_byte_gate,
		output mid_gate,
		output lo_byte_gate,
		output byte_swap,
		output operand_sel
	);

	modport path (
		input hi_byte_gate,
		input mid_gate,
		input lo_byte_gate,
		input byte_swap,
		input operand_sel
	);
endinterface : xop_ctl_if

`default_nettype wire

// ===== hdl/xop_path.sv
// X operand path: working registers, byte operands and X select
//
// Summary of operation
// (RULE_01) Word and working registers are 16 bits
// (RULE_02) accum_one loads shifter word when enabled
// (RULE_03) accum_two, accum_three load only when enabled
// (RULE_04) Load enables independent; any combination loads
// (RULE_05) Loads happen on the phase three strobe
// (RULE_06) X mux has seven sources
// (RULE_07) Codes 0,4,5,6,7: zero, concat, accums
// (RULE_08) Code 1 puts literal on high byte
// (RULE_09) Code 3 puts counter on low byte
// (RULE_10) Select pair picks accum three/two/one/concat
// (RULE_11) All gates false gives zero output
// (RULE_12) Byte gates mask counter and literal bytes
// (RULE_13) Centre gate unused at 16 bits
// (RULE_14) Controls decoded from nanoword bits 17-19
// (RULE_15) Concat: counter high byte, literal low
// (RULE_16) Wider words take centre bits externally
// (RULE_17) Mux output drives the adder X input
// (RULE_18) Literal feeds adder, address and counter
// (RULE_19) Undefined code 2 outputs zero
`timescale 1ns/1ps
`default_nettype none
`include "xop_regs.svh"

module xop_path #(
	parameter int WORD_W = 16,
	parameter int NANO_W = 48
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Microinstruction control
	input  wire logic [NANO_W-1:0] nano_word,
	input  wire logic              phase_three_clock,
	// Datapath inputs
	input  wire logic [WORD_W-1:0] shifter_output,
	input  wire logic [WORD_W-1:0] center_bit_operand_inputs,
	// Microprogram literal and counter actions
	input  wire logic              imm_set,
	input  wire xop_pkg::xop_byte_t imm_value,
	input  wire logic              ctr_load_imm,
	input  wire logic              ctr_inc,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [WORD_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [WORD_W-1:0] reg_rdata,
	// Adder and address outputs
	output logic      [WORD_W-1:0] x_operand,
	output logic      [WORD_W-1:0] imm_mem_addr
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	localparam int CW = WORD_W - 16;

	generate
		if (WORD_W < `XOP_BASE_WORD_W) begin : g_bad_word
			$error("xop_path: WORD_W below 16 is not served");
		end
		if (NANO_W <= `XOP_NB_ACC_LOAD + 2) begin : g_bad_nano
			$error("xop_path: NANO_W too narrow for load bits");
		end
	endgenerate

	// ****************************************
	// Control register decode
	// ****************************************
	xop_ctl_if ctl ();

	// First printed nanobit is the code's most significant bit
	wire xop_pkg::xop_code_t xsel_code = {
		nano_word[`XOP_NB_XSEL_FIRST],
		nano_word[`XOP_NB_XSEL_MID],
		nano_word[`XOP_NB_XSEL_LAST]
	}; // RULE_14

	xop_xsel_ctl u_xsel_ctl (
		.xsel_code_field (xsel_code),
		.ctl             (ctl)
	);

	// ****************************************
	// Register port decode
	// ****************************************
	wire hit_imm  = (reg_addr == `XOP_OFS_IMM);
	wire hit_ctr  = (reg_addr == `XOP_OFS_CTR);
	wire hit_acc1 = (reg_addr == `XOP_OFS_ACC1);
	wire hit_acc2 = (reg_addr == `XOP_OFS_ACC2);
	wire hit_acc3 = (reg_addr == `XOP_OFS_ACC3);
	wire hit_xout = (reg_addr == `XOP_OFS_XOUT);
	wire hit_stat = (reg_addr == `XOP_OFS_STAT);

	wire wr_imm  = reg_wr && hit_imm;
	wire wr_ctr  = reg_wr && hit_ctr;
	wire wr_stat = reg_wr && hit_stat;

	// ****************************************
	// Constant holding register
	// ****************************************
	xop_pkg::xop_byte_t imm_q;
	xop_pkg::xop_byte_t imm_d;

	// Microprogram set wins over a software write in the same cycle
	assign imm_d = imm_set ? imm_value :
		wr_imm ? reg_wdata[7:0] : imm_q; // RULE_18

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			imm_q <= `XOP_RST_BYTE;
		end else begin
			imm_q <= imm_d;
		end
	end

	// ****************************************
	// Count register and overflow flag
	// ****************************************
	xop_pkg::xop_byte_t ctr_q;
	xop_pkg::xop_byte_t ctr_d;
	logic               cov_q;
	logic               cov_d;

	wire [8:0] ctr_sum  = {1'b0, ctr_q} + 9'h001;
	wire       ctr_wrap = ctr_inc && !ctr_load_imm && ctr_sum[8];

	// Literal load is the counter's preset path
	assign ctr_d = ctr_load_imm ? imm_q :
		ctr_inc ? ctr_sum[7:0] :
		wr_ctr ? reg_wdata[7:0] : ctr_q; // RULE_18

	// Overflow set beats a software clear in the same cycle
	assign cov_d = ctr_wrap ? 1'b1 :
		(ctr_load_imm || (wr_stat && reg_wdata[`XOP_STAT_COV])) ?
		1'b0 : cov_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctr_q <= `XOP_RST_BYTE;
			cov_q <= 1'b0;
		end else begin
			ctr_q <= ctr_d;
			cov_q <= cov_d;
		end
	end

	// ****************************************
	// Working registers
	// ****************************************
	logic [WORD_W-1:0] acc_q [3];
	logic [2:0]        acc_load;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_acc
			// Each enable gates the phase three strobe on its own
			assign acc_load[gi] = phase_three_clock &&
				nano_word[`XOP_NB_ACC_LOAD + gi]; // RULE_04 RULE_05

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					acc_q[gi] <= '0;
				end else if (acc_load[gi]) begin
					acc_q[gi] <= shifter_output; // RULE_01 RULE_02 RULE_03
				end
			end
		end
	endgenerate

	// ****************************************
	// Concatenated byte operand
	// ****************************************
	logic [WORD_W-1:0] cat_word;
	logic [WORD_W-1:0] gate_mask;

	generate
		if (CW > 0) begin : g_wide
			// Centre bits come from outside on wider words
			assign cat_word = {ctr_q,
				center_bit_operand_inputs[CW+7:8],
				imm_q}; // RULE_15 RULE_16
			assign gate_mask = {{8{ctl.hi_byte_gate}},
				{CW{ctl.mid_gate}},
				{8{ctl.lo_byte_gate}}};
		end else begin : g_base
			// Centre gate has no bits to steer here
			assign cat_word  = {ctr_q, imm_q}; // RULE_15
			assign gate_mask = {{8{ctl.hi_byte_gate}},
				{8{ctl.lo_byte_gate}}}; // RULE_13
		end
	endgenerate

	wire [WORD_W-1:0] cat_gated = cat_word & gate_mask; // RULE_12

	// Exchange end bytes so a lone byte lands on the opposite lane
	logic [WORD_W-1:0] cat_swapped;

	// No centre lane exists at 16 bits, so only the end bytes move
	generate
		if (CW > 0) begin : g_swap_wide
			assign cat_swapped = {cat_gated[7:0],
				cat_gated[CW+7:8],
				cat_gated[WORD_W-1:WORD_W-8]};
		end else begin : g_swap_base
			assign cat_swapped = {cat_gated[7:0],
				cat_gated[WORD_W-1:WORD_W-8]};
		end
	endgenerate

	wire [WORD_W-1:0] byte_operand = ctl.byte_swap ?
		cat_swapped : cat_gated; // RULE_08 RULE_09

	// ****************************************
	// X select
	// ****************************************
	wire any_gate = ctl.hi_byte_gate || ctl.mid_gate ||
		ctl.lo_byte_gate;

	logic [WORD_W-1:0] x_mux;

	always_comb begin
		case (ctl.operand_sel)
			xop_pkg::XOP_SRC_ACC3: x_mux = acc_q[2];
			xop_pkg::XOP_SRC_ACC2: x_mux = acc_q[1];
			xop_pkg::XOP_SRC_ACC1: x_mux = acc_q[0];
			default:              x_mux = byte_operand;
		endcase // RULE_06 RULE_07 RULE_10
	end

	// Shut gates force zero whatever the select pair says
	wire [WORD_W-1:0] x_sel = any_gate ? x_mux : '0; // RULE_11 RULE_19

	// ****************************************
	// Output registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			x_operand    <= '0;
			imm_mem_addr <= '0;
		end else begin
			x_operand    <= x_sel; // RULE_17
			imm_mem_addr <= {{(WORD_W-8){1'b0}}, imm_q}; // RULE_18
		end
	end

	// ****************************************
	// Status word and read back
	// ****************************************
	logic [WORD_W-1:0] stat_word;

	always_comb begin
		stat_word = '0;
		stat_word[`XOP_STAT_COV]      = cov_q;
		stat_word[`XOP_STAT_HI_GATE]  = ctl.hi_byte_gate;
		stat_word[`XOP_STAT_MID_GATE] = ctl.mid_gate;
		stat_word[`XOP_STAT_LO_GATE]  = ctl.lo_byte_gate;
		stat_word[`XOP_STAT_SWAP]     = ctl.byte_swap;
		stat_word[`XOP_STAT_SEL_LSB +: 2] = ctl.operand_sel;
	end

	// Unmapped offsets read as zero
	wire [WORD_W-1:0] rd_mux =
		hit_imm  ? {{(WORD_W-8){1'b0}}, imm_q} :
		hit_ctr  ? {{(WORD_W-8){1'b0}}, ctr_q} :
		hit_acc1 ? acc_q[0] :
		hit_acc2 ? acc_q[1] :
		hit_acc3 ? acc_q[2] :
		hit_xout ? x_operand :
		hit_stat ? stat_word : '0;

	// Data stand for exactly the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : '0;
		end
	end

endmodule : xop_path

`default_nettype wire

// ===== hdl/xop_pkg.sv
// Types shared by the X operand path modules
package xop_pkg;

	typedef logic [7:0] xop_byte_t;
	typedef logic [2:0] xop_code_t;

	// Order matches {operand_sel_hi, operand_sel_lo}
	typedef enum logic [1:0] {
		XOP_SRC_ACC3,
		XOP_SRC_ACC2,
		XOP_SRC_ACC1,
		XOP_SRC_CAT
	} xop_src_t;

endpackage : xop_pkg

// ===== hdl/xop_regs.svh
// Register offsets, field positions, reset values and codes of the X operand path
`ifndef XOP_REGS_SVH
`define XOP_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define XOP_OFS_IMM     8'h00
`define XOP_OFS_CTR     8'h04
`define XOP_OFS_ACC1    8'h08
`define XOP_OFS_ACC2    8'h0c
`define XOP_OFS_ACC3    8'h10
`define XOP_OFS_XOUT    8'h14
`define XOP_OFS_STAT    8'h18

// ****************************************
// Nanoword field positions
// ****************************************
`define XOP_NB_XSEL_FIRST 17
`define XOP_NB_XSEL_MID   18
`define XOP_NB_XSEL_LAST  19
`define XOP_NB_ACC_LOAD   34

// ****************************************
// Status register fields
// ****************************************
`define XOP_STAT_COV      0
`define XOP_STAT_HI_GATE  1
`define XOP_STAT_MID_GATE 2
`define XOP_STAT_LO_GATE  3
`define XOP_STAT_SWAP     4
`define XOP_STAT_SEL_LSB  5

// ****************************************
// Reset values and sizes
// ****************************************
`define XOP_RST_BYTE     8'h00
`define XOP_BYTE_W       8
`define XOP_BASE_WORD_W  16

// ****************************************
// X select codes
// ****************************************
`define XOP_X_ZERO    3'h0
`define XOP_X_IMM     3'h1
`define XOP_X_UNDEF   3'h2
`define XOP_X_CTR     3'h3
`define XOP_X_CAT     3'h4
`define XOP_X_ACC1    3'h5
`define XOP_X_ACC2    3'h6
`define XOP_X_ACC3    3'h7

`endif

// ===== hdl/xop_xsel_ctl.sv
// Control register decode of the X select code into gates and selects
`timescale 1ns/1ps
`default_nettype none
`include "xop_regs.svh"

module xop_xsel_ctl (
	// Code field
	input  wire xop_pkg::xop_code_t xsel_code_field,
	// Decoded controls
	xop_ctl_if.decoder              ctl
);

	// ****************************************
	// Decode
	// ****************************************
	wire is_acc  = xsel_code_field[2] && (xsel_code_field[1:0] != 2'b00);
	wire is_cat  = (xsel_code_field == `XOP_X_CAT);
	wire is_imm  = (xsel_code_field == `XOP_X_IMM);
	wire is_ctr  = (xsel_code_field == `XOP_X_CTR);

	// Counter byte opens the high gate, literal byte the low gate
	assign ctl.hi_byte_gate = is_acc || is_cat || is_ctr; // RULE_12
	assign ctl.lo_byte_gate = is_acc || is_cat || is_imm; // RULE_12
	// Centre gate only matters above 16 bits
	assign ctl.mid_gate     = is_acc || is_cat; // RULE_13
	// Single-byte codes land on the opposite byte lane
	assign ctl.byte_swap    = is_imm || is_ctr; // RULE_08 RULE_09
	// Zero and undefined codes keep every gate shut
	assign ctl.operand_sel  = is_acc ?
		xop_pkg::xop_src_t'(~xsel_code_field[1:0]) :
		xop_pkg::XOP_SRC_CAT; // RULE_10 RULE_19

endmodule : xop_xsel_ctl

`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the X operand path
`timescale 1ns/1ps
`default_nettype none
`include "xop_regs.svh"

module tb_top;
	logic               clk = 1'h0;
	logic               rst_n = 1'h0;
	xop_pkg::xop_code_t code = 3'h0;
	logic [2:0]         loads = 3'h0;
	logic               p3 = 1'h0;
	logic [15:0]        shw = 16'h0000;
	logic               imm_set = 1'h0;
	xop_pkg::xop_byte_t imm_value = 8'h00;
	logic               ctr_load = 1'h0;
	logic               ctr_inc = 1'h0;
	logic [7:0]         addr = 8'h00;
	logic [15:0]        wdata = 16'h0000;
	logic               wr = 1'h0;
	logic               rd = 1'h0;
	logic [15:0]        rdata, x_op, imm_addr, got;
	logic [47:0]        nano;
	logic [18:0]        rows [8];
	int                 failures = 0;
	int                 n_compared = 0;

	always #5 clk = ~clk;

	xop_nano_src u_src (.clk, .rst_n, .code, .loads, .nano_word(nano));

	// Centre inputs held high: ignored at this width
	xop_path #(.WORD_W(16), .NANO_W(48)) DUT (
		.clk, .rst_n, .nano_word(nano), .phase_three_clock(p3),
		.shifter_output(shw), .center_bit_operand_inputs(16'hffff),
		.imm_set, .imm_value, .ctr_load_imm(ctr_load), .ctr_inc,
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .x_operand(x_op), .imm_mem_addr(imm_addr));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic ld(input logic [2:0] l, input logic s, input logic [15:0] w);
		@(posedge clk);
		loads <= l;
		p3 <= s;
		shw <= w;
	endtask : ld

	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 got = rdata;
	endtask : reg_read

	task automatic final_report;
		if (failures == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		#20000;
		failures++;
		final_report;
	end

	initial begin
		rows = '{{3'h0, 16'h0000}, {3'h1, 16'hc400}, {3'h2, 16'h0000},
			{3'h3, 16'h005b}, {3'h4, 16'h5bc4}, {3'h5, 16'h1111},
			{3'h6, 16'haaaa}, {3'h7, 16'h3333}};
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		#1 chk(x_op, 16'h0000);
		chk(imm_addr, 16'h0000);
		ld(3'h7, 1'h1, 16'haaaa);
		ld(3'h1, 1'h1, 16'h1111);
		ld(3'h4, 1'h1, 16'h3333);
		ld(3'h1, 1'h0, 16'hbeef);
		ld(3'h0, 1'h1, 16'h7777);
		ld(3'h0, 1'h0, 16'h0000);
		@(posedge clk);
		imm_set <= 1'h1;
		imm_value <= 8'h5a;
		@(posedge clk);
		imm_set <= 1'h0;
		ctr_load <= 1'h1;
		@(posedge clk);
		ctr_load <= 1'h0;
		ctr_inc <= 1'h1;
		@(posedge clk);
		ctr_inc <= 1'h0;
		reg_write(`XOP_OFS_IMM, 16'hffc4);
		foreach (rows[i]) begin
			@(posedge clk);
			code <= rows[i][18:16];
			@(posedge clk);
			#1 chk(x_op, rows[i][15:0]);
		end
		// Load accum_three while it is selected
		ld(3'h4, 1'h1, 16'h2468);
		ld(3'h0, 1'h0, 16'h0000);
		@(posedge clk);
		#1 chk(x_op, 16'h2468);
		chk(imm_addr, 16'h00c4);
		reg_read(`XOP_OFS_XOUT);
		chk(got, 16'h2468);
		reg_read(`XOP_OFS_STAT);
		chk(got, 16'h000e);
		reg_read(`XOP_OFS_ACC2);
		chk(got, 16'haaaa);
		reg_read(`XOP_OFS_CTR);
		chk(got, 16'h005b);
		reg_read(8'h1c);
		chk(got, 16'h0000);
		// Reset in mid-run must clear accum_one, seen through code 5
		@(posedge clk);
		rst_n <= 1'h0;
		code <= 3'h5;
		@(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		#1 chk(x_op, 16'h0000);
		// Select accum_one then accum_two right after loading each
		ld(3'h1, 1'h1, 16'h5a5a);
		ld(3'h2, 1'h1, 16'h0f0f);
		@(posedge clk);
		code <= 3'h6;
		#1 chk(x_op, 16'h5a5a);
		ld(3'h0, 1'h0, 16'h0000);
		#1 chk(x_op, 16'h0f0f);
		// Let the checker see the last loads through
		repeat (3) @(posedge clk);
		final_report;
	end
endmodule : tb_top

`default_nettype wire

// ===== verification/xop_nano_src.sv
// Control register model that assembles the nanoword
`timescale 1ns/1ps
`default_nettype none

module xop_nano_src (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Fields to place
	input  wire xop_pkg::xop_code_t code,
	input  wire logic [2:0]         loads,
	// Nanoword
	output logic [47:0]             nano_word
);
	// Unrelated bits keep toggling so stray decode shows up
	logic [47:0] fill_q;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) fill_q <= 48'h0;
		else fill_q <= {fill_q[46:0], ~fill_q[47]};
	assign nano_word = {fill_q[47:37], loads, fill_q[33:20],
		code[0], code[1], code[2], fill_q[16:0]};
endmodule : xop_nano_src

`default_nettype wire

// ===== verification/xop_path_properties.sv
// Port-level checker for the X operand path
`timescale 1ns/1ps
`default_nettype none

module xop_path_checker #(
	parameter int WORD_W = 16,
	parameter int NANO_W = 48
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// Control and data
	input wire logic [NANO_W-1:0] nano_word,
	input wire logic              phase_three_clock,
	input wire logic [WORD_W-1:0] shifter_output,
	// Results
	input wire logic [WORD_W-1:0] x_operand,
	input wire logic [WORD_W-1:0] imm_mem_addr
);
	// ****************************************
	// Select code and load relations
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [2:0] code;
	assign code = {nano_word[17], nano_word[18], nano_word[19]};

	property p_load(logic en, logic [2:0] c);
		(phase_three_clock && en) ##1 code == c
			|=> x_operand == $past(shifter_output, 2);
	endproperty

	// Enable without strobe must not load
	property p_hold(logic en, logic [2:0] c);
		(code == c && !(phase_three_clock && en)) ##1 code == c
			|=> $stable(x_operand);
	endproperty

	a_load_acc_one: assert property (p_load(nano_word[34], 3'h5))
		else $error("accum_one did not take the shifter word");
	a_load_acc_two: assert property (p_load(nano_word[35], 3'h6))
		else $error("accum_two did not take the shifter word");
	a_load_acc_three: assert property (p_load(nano_word[36], 3'h7))
		else $error("accum_three did not take the shifter word");
	a_hold_acc_one: assert property (p_hold(nano_word[34], 3'h5))
		else $error("accum_one changed without a load");
	a_hold_acc_three: assert property (p_hold(nano_word[36], 3'h7))
		else $error("accum_three changed without a load");
	a_zero_code: assert property (code == 3'h0 |=> x_operand == '0)
		else $error("zero select gave a nonzero operand");
	a_undef_code_zero: assert property (code == 3'h2 |=> x_operand == '0)
		else $error("undefined select gave a nonzero operand");
	a_lit_low_clear: assert property (code == 3'h1 |=> x_operand[7:0] == 8'h00)
		else $error("literal select leaked into the low byte");
	a_ctr_high_clear: assert property (
		code == 3'h3 |=> x_operand[WORD_W-1:8] == '0)
		else $error("counter select leaked into the high byte");
	a_addr_upper_zero: assert property (imm_mem_addr[WORD_W-1:8] == '0)
		else $error("literal address not zero extended");

	c_all_loads: cover property (phase_three_clock && &nano_word[36:34]);
	c_concat: cover property (code == 3'h4);
	c_undef: cover property (code == 3'h2);
endmodule : xop_path_checker

bind xop_path xop_path_checker #(.WORD_W(WORD_W), .NANO_W(NANO_W)) u_chk (
	.clk, .rst_n, .nano_word, .phase_three_clock, .shifter_output,
	.x_operand, .imm_mem_addr);

`default_nettype wire
